// ===== rtl/dds_slave_regs.sv
`timescale 1ns/10ps
module dds_slave_regs (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [15:4] I_DMA_BASE,
   input wire logic [15:0] I_IO_ADDR,
   input wire logic [3:0] I_IO_BE,
   input wire logic I_IO_WR,
   input wire logic I_IO_RD,
   input wire logic [31:0] I_IO_WDATA,
   input wire logic I_XFER_DONE,
   input wire logic I_XFER_16BIT,
   input wire logic I_ADDRESS_DIRECTION,
   input wire logic I_CHANNEL_RESET,
   input wire logic I_CARD_REQUEST,
   output logic [31:0] O_IO_RDATA,
   output logic O_IO_HIT,
   output logic [23:0] O_ADDR_PHASE_AD,
   output logic O_CONTROLLER_DISABLED,
   output logic O_TERMINAL_COUNT
);
   typedef struct packed {
      logic [15:0] base_addr;
      logic [15:0] cur_addr;
      logic [7:0] page;
      logic [15:0] base_count;
      logic [15:0] cur_count;
      logic [7:0] cmd;
      logic [3:0] term_flags;
      logic [31:0] rdata;
      logic hit;
      logic [23:0] ad;
      logic term_pulse;
   } dds_state_t;

   dds_state_t st_q;
   dds_state_t st_d;
   logic request_level;

   dds_pin_sync u_req_sync (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_pin(I_CARD_REQUEST),
      .o_level(request_level)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // Lane of a register offset
   function automatic logic lane_on(input logic [3:0] be, input logic [3:0] ofs);
      lane_on = be[ofs[1:0]];
   endfunction

   // Address after one transfer
   function automatic logic [15:0] next_addr(input logic [15:0] addr, input logic down);
      if (down) begin
         next_addr = addr - dds_pkg::ADDR_STEP;
      end else begin
         next_addr = addr + dds_pkg::ADDR_STEP;
      end
   endfunction

   // Last transfer of a run
   function automatic logic count_ends(input logic [15:0] count, input logic [15:0] stp);
      count_ends = (count <= stp);
   endfunction

   // Request in upper nibble, terminal count in lower
   function automatic logic [7:0] status_byte(input logic req, input logic [3:0] term);
      status_byte = {{4{req}}, term};
   endfunction

   // Address phase image
   function automatic logic [23:0] ad_image(input logic [7:0] pg, input logic [15:0] addr,
      input logic wide);
      if (wide) begin
         ad_image = {pg[7:1], addr, 1'b0};
      end else begin
         ad_image = {pg, addr};
      end
   endfunction

   // Read word; unmapped lanes and words zero
   function automatic logic [31:0] read_word(input logic [1:0] sel, input logic [7:0] pg,
      input logic [15:0] addr, input logic [15:0] count, input logic [7:0] status);
      case (sel)
         dds_pkg::DW_ADDRESS: begin
            read_word = {8'h00, pg, addr};
         end
         dds_pkg::DW_COUNT: begin
            read_word = {16'h0000, count};
         end
         dds_pkg::DW_CMD: begin
            read_word = {24'h000000, status};
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   logic in_window;
   logic [1:0] dw;
   logic [15:0] step;
   logic [15:0] wd16;
   logic [1:0] be16;
   logic wr_hit;
   logic rd_hit;
   logic status_rd;

   assign in_window = (I_IO_ADDR[15:dds_pkg::WIN_BASE_LSB] == I_DMA_BASE);
   assign dw = I_IO_ADDR[3:2];
   assign step = I_XFER_16BIT ? dds_pkg::STEP_16BIT : dds_pkg::STEP_8BIT;
   assign wd16 = I_IO_WDATA[15:0];
   assign be16 = I_IO_BE[1:0];
   assign wr_hit = I_IO_WR && in_window;
   assign rd_hit = I_IO_RD && in_window;
   assign status_rd = rd_hit && (dw == dds_pkg::DW_CMD) && lane_on(I_IO_BE, dds_pkg::OFS_CMD);

   always_comb begin
      st_d = st_q;
      st_d.hit = wr_hit || rd_hit;
      st_d.term_pulse = 1'b0;

      // Register writes; unmapped lanes ignored
      if (wr_hit) begin
         case (dw)
            dds_pkg::DW_ADDRESS: begin
               st_d.cur_addr = merge16(st_q.cur_addr, wd16, be16);
               st_d.base_addr = merge16(st_q.base_addr, wd16, be16);
               if (lane_on(I_IO_BE, dds_pkg::OFS_PAGE)) begin
                  st_d.page = I_IO_WDATA[23:16];
               end
            end
            dds_pkg::DW_COUNT: begin
               st_d.cur_count = merge16(st_q.cur_count, wd16, be16);
               st_d.base_count = merge16(st_q.base_count, wd16, be16);
            end
            dds_pkg::DW_CMD: begin
               if (lane_on(I_IO_BE, dds_pkg::OFS_CMD)) begin
                  st_d.cmd = I_IO_WDATA[7:0] & dds_pkg::CMD_WRITE_MASK;
               end
            end
            default: begin
               st_d.cmd = st_q.cmd;
            end
         endcase
      end

      // Status read or channel reset clears terminal count bits
      if (status_rd || I_CHANNEL_RESET) begin
         st_d.term_flags = 4'h0;
      end

      // Transfer progress; setting terminal count wins over clear
      if (I_XFER_DONE && !st_q.cmd[dds_pkg::CMD_DISABLE_BIT]) begin
         st_d.cur_count = st_q.cur_count - step;
         st_d.cur_addr = next_addr(st_q.cur_addr, I_ADDRESS_DIRECTION);
         if (count_ends(st_q.cur_count, step)) begin
            st_d.term_flags = dds_pkg::STAT_TERM_ONES;
            st_d.term_pulse = 1'b1;
         end
      end

      // Read data, registered one cycle after the strobe
      st_d.rdata = 32'h0000_0000;
      if (rd_hit) begin
         st_d.rdata = read_word(dw, st_q.page, st_q.cur_addr, st_q.cur_count,
            status_byte(request_level, st_q.term_flags));
      end

      // Address phase image of the current transfer
      st_d.ad = ad_image(st_d.page, st_d.cur_addr, I_XFER_16BIT);
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_q <= '0;
         st_q.cur_addr <= dds_pkg::RST_ADDRESS;
         st_q.base_addr <= dds_pkg::RST_ADDRESS;
         st_q.page <= dds_pkg::RST_PAGE;
         st_q.cur_count <= dds_pkg::RST_COUNT;
         st_q.base_count <= dds_pkg::RST_COUNT;
         st_q.cmd <= dds_pkg::RST_CMD;
      end else begin
         st_q <= st_d;
      end
   end

   assign O_IO_RDATA = st_q.rdata;
   assign O_IO_HIT = st_q.hit;
   assign O_ADDR_PHASE_AD = st_q.ad;
   assign O_CONTROLLER_DISABLED = st_q.cmd[dds_pkg::CMD_DISABLE_BIT];
   assign O_TERMINAL_COUNT = st_q.term_pulse;
endmodule

// ===== rtl/dds_pkg.sv
package dds_pkg;
   // Register window
   localparam int unsigned WIN_BASE_LSB = 4;
   localparam logic [1:0] DW_ADDRESS = 2'h0;
   localparam logic [1:0] DW_COUNT = 2'h1;
   localparam logic [1:0] DW_CMD = 2'h2;
   // Byte offsets within the window
   localparam logic [3:0] OFS_ADDRESS = 4'h0;
   localparam logic [3:0] OFS_PAGE = 4'h2;
   localparam logic [3:0] OFS_COUNT = 4'h4;
   localparam logic [3:0] OFS_CMD = 4'h8;
   // Command and status fields
   localparam int unsigned CMD_DISABLE_BIT = 2;
   localparam logic [7:0] CMD_WRITE_MASK = 8'h04;
   localparam logic [3:0] STAT_TERM_ONES = 4'hF;
   // Reset values
   localparam logic [15:0] RST_ADDRESS = 16'h0000;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [7:0] RST_CMD = 8'h00;
   // Steps per transfer
   localparam logic [15:0] STEP_8BIT = 16'h0001;
   localparam logic [15:0] STEP_16BIT = 16'h0002;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
endpackage

// ===== rtl/dds_pin_sync.sv
`timescale 1ns/10ps
module dds_pin_sync (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   output logic o_level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } dds_sync_t;

   dds_sync_t st_q;
   dds_sync_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = i_pin;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // Change taken once second and third stages agree
      if (st_q.s2 == st_q.s3) begin
         st_d.level = st_q.s3;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_level = st_q.level;
endmodule

// ===== tb/dds_slave_regs_sva.sv
`timescale 1ns/10ps
module dds_slave_regs_chk (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [15:4] I_DMA_BASE,
   input wire logic [15:0] I_IO_ADDR,
   input wire logic [3:0] I_IO_BE,
   input wire logic I_IO_WR,
   input wire logic I_IO_RD,
   input wire logic [31:0] I_IO_WDATA,
   input wire logic I_XFER_DONE,
   input wire logic I_XFER_16BIT,
   input wire logic [31:0] O_IO_RDATA,
   input wire logic O_IO_HIT,
   input wire logic [23:0] O_ADDR_PHASE_AD,
   input wire logic O_CONTROLLER_DISABLED,
   input wire logic O_TERMINAL_COUNT
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   wire logic hit = (I_IO_WR || I_IO_RD) && I_IO_ADDR[15:4] == I_DMA_BASE;
   wire logic rd = hit && I_IO_RD;
   wire logic wr = hit && I_IO_WR;
   wire logic [1:0] dw = I_IO_ADDR[3:2];
   hit_timing_a: assert property (O_IO_HIT == $past(hit))
      else $error("hit late");
   idle_rdata_a: assert property (!$past(rd) |-> O_IO_RDATA == 32'h0)
      else $error("read data not idle");
   dw3_zero_a: assert property ($past(rd && dw == 2'h3) |-> O_IO_RDATA == 32'h0)
      else $error("reserved word not zero");
   dw1_upper_a: assert property ($past(rd && dw == 2'h1) |-> O_IO_RDATA[31:16] == 16'h0)
      else $error("count upper half not zero");
   status_form_a: assert property ($past(rd && dw == 2'h2) |->
      O_IO_RDATA[31:8] == 24'h0 && O_IO_RDATA[7:4] inside {4'h0, 4'hF}
      && O_IO_RDATA[3:0] inside {4'h0, 4'hF}) else $error("status layout");
   ad_low_a: assert property ($past(I_XFER_16BIT) |-> !O_ADDR_PHASE_AD[0])
      else $error("address bit 0 not low");
   cmd_write_a: assert property ($past(wr && dw == 2'h2 && I_IO_BE[0]) |->
      O_CONTROLLER_DISABLED == $past(I_IO_WDATA[2])) else $error("command bit not written");
   term_cause_a: assert property (O_TERMINAL_COUNT |->
      $past(I_XFER_DONE && !O_CONTROLLER_DISABLED)) else $error("terminal count without transfer");
   cover property (O_TERMINAL_COUNT);
   cover property ($rose(O_CONTROLLER_DISABLED));
   cover property (rd ##1 O_IO_RDATA[7:0] == 8'hF0);
endmodule
bind dds_slave_regs dds_slave_regs_chk dds_slave_regs_chk_inst (.I_CLK(I_CLK), .I_RST(I_RST),
   .I_DMA_BASE(I_DMA_BASE), .I_IO_ADDR(I_IO_ADDR), .I_IO_BE(I_IO_BE), .I_IO_WR(I_IO_WR),
   .I_IO_RD(I_IO_RD), .I_IO_WDATA(I_IO_WDATA), .I_XFER_DONE(I_XFER_DONE),
   .I_XFER_16BIT(I_XFER_16BIT), .O_IO_RDATA(O_IO_RDATA), .O_IO_HIT(O_IO_HIT),
   .O_ADDR_PHASE_AD(O_ADDR_PHASE_AD), .O_CONTROLLER_DISABLED(O_CONTROLLER_DISABLED),
   .O_TERMINAL_COUNT(O_TERMINAL_COUNT));

// ===== tb/dds_dma_master.sv
`timescale 1ns/10ps
module dds_dma_master (
   input wire logic i_clk,
   input wire logic i_start,
   input wire logic [3:0] i_n,
   output logic o_done
);
   logic [3:0] left = 4'h0;
   initial o_done = 1'b0;
   always @(posedge i_clk) begin
      if (i_start) left <= i_n;
      o_done <= !o_done && left != 4'h0;
      if (!o_done && left != 4'h0) left <= left - 4'h1;
   end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, m16 = 1'b0, dir = 1'b0, req = 1'b0;
   logic go = 1'b0, crst = 1'b0, hit, done, dis, term;
   logic [15:0] a = 16'h0000;
   logic [3:0] be = 4'h0, n = 4'h0;
   logic [31:0] wd = 32'h0, rdata, q;
   logic [23:0] ad;
   int mismatches = 0, cmp_count = 0, cyc = 0, tcs = 0;
   always #10 clk = ~clk;
   dds_slave_regs dds_slave_regs_inst (.I_CLK(clk), .I_RST(rst), .I_DMA_BASE(12'h0A5),
      .I_IO_ADDR(a), .I_IO_BE(be), .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wd),
      .I_XFER_DONE(done), .I_XFER_16BIT(m16), .I_ADDRESS_DIRECTION(dir),
      .I_CHANNEL_RESET(crst), .I_CARD_REQUEST(req), .O_IO_RDATA(rdata), .O_IO_HIT(hit),
      .O_ADDR_PHASE_AD(ad), .O_CONTROLLER_DISABLED(dis), .O_TERMINAL_COUNT(term));
   dds_dma_master dds_dma_master_inst (.i_clk(clk), .i_start(go), .i_n(n), .o_done(done));
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (term === 1'b1) tcs++;
      if (cyc == 3000) begin
         mismatches++;
         results;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic io(input logic w, input logic [15:0] ad_i, input logic [3:0] b,
      input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      a <= ad_i;
      be <= b;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 q = rdata;
      chk({31'h0, hit}, {31'h0, ad_i[15:4] == 12'h0A5});
   endtask
   task automatic xfer(input logic [3:0] k);
      @(posedge clk);
      go <= 1'b1;
      n <= k;
      @(posedge clk);
      go <= 1'b0;
      repeat (2 * k + 3) @(posedge clk);
   endtask
   task automatic t_regs;
      io(0, 16'h0A58, 4'h1, 32'h0);
      chk(q, 32'h0);
      io(1, 16'h0A50, 4'h7, 32'hFFAA1234);
      io(0, 16'h0A50, 4'hF, 32'h0);
      chk(q, 32'h00AA1234);
      chk({8'h0, ad}, 32'h00AA1234);
      io(1, 16'h0A54, 4'hF, 32'hFFFF0003);
      io(1, 16'h0A58, 4'h1, 32'h000000FF);
      chk({31'h0, dis}, 32'h1);
      xfer(1);
      io(1, 16'h0A58, 4'h1, 32'h0);
      chk({31'h0, dis}, 32'h0);
      io(1, 16'h0A5C, 4'hF, 32'hFFFFFFFF);
      io(1, 16'h0A64, 4'hF, 32'hFFFFFFFF);
      io(0, 16'h0A54, 4'hF, 32'h0);
      chk(q, 32'h00000003);
      $display("registers test done");
   endtask
   task automatic t_xfer;
      xfer(3);
      io(0, 16'h0A50, 4'hF, 32'h0);
      chk(q, 32'h00AA1237);
      chk(tcs, 1);
      io(0, 16'h0A58, 4'h1, 32'h0);
      chk(q, 32'h0000000F);
      @(posedge clk);
      m16 <= 1'b1;
      dir <= 1'b1;
      io(1, 16'h0A50, 4'h7, 32'h00AB1234);
      io(1, 16'h0A54, 4'h3, 32'h00000004);
      xfer(2);
      io(0, 16'h0A54, 4'hF, 32'h0);
      chk(q, 32'h0);
      chk({8'h0, ad}, 32'h00AA2464);
      @(posedge clk);
      req <= 1'b1;
      repeat (6) @(posedge clk);
      io(0, 16'h0A58, 4'h1, 32'h0);
      chk(q, 32'h000000FF);
      io(0, 16'h0A58, 4'h1, 32'h0);
      chk(q, 32'h000000F0);
      $display("transfer test done");
   endtask
   task automatic t_clear;
      io(1, 16'h0A54, 4'h3, 32'h00000002);
      xfer(1);
      @(posedge clk);
      crst <= 1'b1;
      @(posedge clk);
      crst <= 1'b0;
      io(0, 16'h0A58, 4'h1, 32'h0);
      chk(q, 32'h000000F0);
      chk(tcs, 3);
      $display("channel reset test done");
   endtask
   task automatic t_reset;
      io(1, 16'h0A58, 4'h1, 32'h00000004);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      io(0, 16'h0A50, 4'hF, 32'h0);
      chk(q, 32'h0);
      chk({8'h0, ad}, 32'h0);
      chk({31'h0, dis}, 32'h0);
      io(0, 16'h0A54, 4'hF, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_xfer;
      t_clear;
      t_reset;
      results;
   end
endmodule
